// *** anxr_pkg.sv ***
// Constants for the auto-negotiation expansion and next page registers
//==============================================================================
// Overview of operation
// - Reads of the reserved upper eleven expansion bits return zero.
// - Override-write bits accept writes only while override control is one.
// - A parallel detection fault sets a latching-high fault flag.
// - Partner next-page ability copies the next-page bit of its base word.
// - The local-next-page-capable bit always reads one.
// - Each newly stored partner code word sets the page-received flag.
// - A read of the expansion register clears the page-received flag.
// - Partner auto-negotiation ability sets once valid bursts arrive.
// - The transmitted next-page word is built from the transmit register.
// - The comply bit drives the transmitted acknowledge-two bit.
// - The eleven-bit code field is sent unchanged, default 0x001.
// - Toggle inverts per sent page, first the inverse of base bit 11.
// - The transmitted more-pages bit follows the register bit.
// - The transmitted message-page bit follows the register bit.
package anxr_pkg;
   localparam logic [4:0] ANXR_ADDR_EXP = 5'h06;
   localparam logic [4:0] ANXR_ADDR_NPT = 5'h07;
   localparam logic [15:0] ANXR_EXP_RESET = 16'h0004;
   localparam logic [15:0] ANXR_NPT_RESET = 16'h2001;
   localparam int ANXR_EXP_PDF = 4;
   localparam int ANXR_EXP_LPNP = 3;
   localparam int ANXR_EXP_NPA = 2;
   localparam int ANXR_EXP_PR = 1;
   localparam int ANXR_EXP_LPAN = 0;
   localparam int ANXR_NPT_MORE = 15;
   localparam int ANXR_NPT_RSV = 14;
   localparam int ANXR_NPT_MSG = 13;
   localparam int ANXR_NPT_ACK = 12;
   localparam int ANXR_NPT_TOG = 11;
   localparam int ANXR_BASE_TOG = 11;
   localparam logic [10:0] ANXR_CODE_RESET = 11'h001;
endpackage : anxr_pkg

// *** anxr_latch.sv ***
// Latching-high status flag cleared by a register read
`timescale 1ns/1ps
`default_nettype none
module anxr_latch (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Event and clear
   input wire logic i_set,
   input wire logic i_clr,
   output logic o_flag
);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clr) begin
         o_flag <= 1'b0;
      end
   end
endmodule : anxr_latch
`default_nettype wire

// *** anxr_toggle.sv ***
// Toggle bit tracking for transmitted next pages
`timescale 1ns/1ps
`default_nettype none
module anxr_toggle (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Page events
   input wire logic i_base_sent,
   input wire logic i_base_bit11,
   input wire logic i_page_sent,
   output logic o_toggle
);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_toggle <= 1'b0;
      end else if (i_base_sent) begin
         o_toggle <= ~i_base_bit11;
      end else if (i_page_sent) begin
         o_toggle <= ~o_toggle;
      end
   end
endmodule : anxr_toggle
`default_nettype wire

// *** anxr_regs.sv ***
// Auto-negotiation expansion and next page transmit register bank
`timescale 1ns/1ps
`default_nettype none
module anxr_regs (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Management access
   input wire logic [4:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   input wire logic i_override_en,
   // Auto-negotiation events
   input wire logic i_pd_fault,
   input wire logic i_page_stored,
   input wire logic i_partner_np,
   input wire logic i_flp_valid,
   input wire logic i_base_sent,
   input wire logic [15:0] i_base_word,
   input wire logic i_page_sent,
   // Next page word out
   output logic [15:0] o_np_word
);
   import anxr_pkg::*;

   //===========================================================================
   // Address match, shared by strobe decode and read mux
   function automatic logic addr_is(input logic [4:0] addr,
      input logic [4:0] target);
      return addr == target;
   endfunction : addr_is

   //===========================================================================
   // Reset synchroniser
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   //===========================================================================
   // Decode
   logic exp_rd;
   logic npt_wr;
   logic exp_wr;
   assign exp_rd = i_reg_rd && addr_is(i_reg_addr, ANXR_ADDR_EXP);
   assign npt_wr = i_reg_wr && addr_is(i_reg_addr, ANXR_ADDR_NPT);
   assign exp_wr = i_reg_wr && addr_is(i_reg_addr, ANXR_ADDR_EXP);

   //===========================================================================
   // Expansion status
   logic pdf;
   logic pr;
   logic lpnp_q;
   logic lpan_q;
   logic [10:0] exp_rsv_q;

   anxr_latch u_pdf (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_set(i_pd_fault),
      .i_clr(exp_rd),
      .o_flag(pdf)
   );

   anxr_latch u_pr (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_set(i_page_stored),
      .i_clr(exp_rd),
      .o_flag(pr)
   );

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         lpnp_q <= 1'b0;
         lpan_q <= 1'b0;
      end else begin
         if (i_page_stored) begin
            lpnp_q <= i_partner_np;
         end
         if (i_flp_valid) begin
            lpan_q <= 1'b1;
         end
      end
   end

   // Override-write reserved storage, never visible on reads
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         exp_rsv_q <= ANXR_EXP_RESET[15:5];
      end else if (exp_wr && i_override_en) begin
         exp_rsv_q <= i_reg_wdata[15:5];
      end
   end

   //===========================================================================
   // Next page transmit
   logic more_pages_bit_q;
   logic message_page_bit_q;
   logic comply_ack_bit_q;
   logic [10:0] code_q;
   logic tog;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         more_pages_bit_q <= ANXR_NPT_RESET[ANXR_NPT_MORE];
         message_page_bit_q <= ANXR_NPT_RESET[ANXR_NPT_MSG];
         comply_ack_bit_q <= ANXR_NPT_RESET[ANXR_NPT_ACK];
         code_q <= ANXR_CODE_RESET;
      end else if (npt_wr) begin
         more_pages_bit_q <= i_reg_wdata[ANXR_NPT_MORE];
         message_page_bit_q <= i_reg_wdata[ANXR_NPT_MSG];
         comply_ack_bit_q <= i_reg_wdata[ANXR_NPT_ACK];
         code_q <= i_reg_wdata[10:0];
      end
   end

   anxr_toggle u_tog (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_base_sent(i_base_sent),
      .i_base_bit11(i_base_word[ANXR_BASE_TOG]),
      .i_page_sent(i_page_sent),
      .o_toggle(tog)
   );

   logic [15:0] npt_val;
   logic [15:0] exp_val;
   always_comb begin
      npt_val = 16'h0000;
      npt_val[ANXR_NPT_MORE] = more_pages_bit_q;
      npt_val[ANXR_NPT_RSV] = 1'b0;
      npt_val[ANXR_NPT_MSG] = message_page_bit_q;
      npt_val[ANXR_NPT_ACK] = comply_ack_bit_q;
      npt_val[ANXR_NPT_TOG] = tog;
      npt_val[10:0] = code_q;
      exp_val = 16'h0000;
      exp_val[ANXR_EXP_PDF] = pdf;
      exp_val[ANXR_EXP_LPNP] = lpnp_q;
      exp_val[ANXR_EXP_NPA] = 1'b1;
      exp_val[ANXR_EXP_PR] = pr;
      exp_val[ANXR_EXP_LPAN] = lpan_q;
   end

   //===========================================================================
   // Outputs
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_np_word <= ANXR_NPT_RESET;
      end else begin
         o_np_word <= npt_val;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         if (addr_is(i_reg_addr, ANXR_ADDR_EXP)) begin
            o_reg_rdata <= exp_val;
         end else if (addr_is(i_reg_addr, ANXR_ADDR_NPT)) begin
            o_reg_rdata <= npt_val;
         end else begin
            o_reg_rdata <= 16'h0000;
         end
      end
   end
endmodule : anxr_regs
`default_nettype wire

// *** anxr_regs_monitor.sv ***
// Checker on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module anxr_regs_monitor (
   // Watched ports
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic i_override_en,
   input wire logic i_pd_fault,
   input wire logic i_page_stored,
   input wire logic i_partner_np,
   input wire logic i_flp_valid,
   input wire logic i_base_sent,
   input wire logic [15:0] i_base_word,
   input wire logic i_page_sent,
   input wire logic [15:0] o_np_word
);
   //==========================================================
   // Properties
   wire logic rd6 = i_reg_rd && i_reg_addr == 5'h06;
   wire logic wr7 = i_reg_wr && i_reg_addr == 5'h07;
   wire logic ps = i_page_stored;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   chk_rsv_zero: assert property (
      rd6 |=> o_reg_rdata[15:5] == 11'h000)
      else $error("reserved bits nonzero");
   chk_local_np: assert property (rd6 |=> o_reg_rdata[2])
      else $error("local next page bit low");
   chk_fault_set: assert property (
      i_pd_fault ##1 !rd6 ##1 rd6 |=> o_reg_rdata[4])
      else $error("fault flag not latched");
   chk_page_set: assert property (
      ps ##1 !rd6 ##1 rd6 |=> o_reg_rdata[1])
      else $error("page flag not latched");
   chk_page_clear: assert property (
      rd6 && !ps ##1 !ps [*2] ##1 rd6 && !ps |=> !o_reg_rdata[1])
      else $error("page flag not cleared");
   chk_lpan_set: assert property (
      i_flp_valid ##1 !rd6 ##1 rd6 |=> o_reg_rdata[0])
      else $error("partner able bit low");
   chk_lpnp_set: assert property (
      ps && i_partner_np ##1 !ps ##1 rd6 && !ps |=> o_reg_rdata[3])
      else $error("partner next page bit low");
   chk_word_mirror: assert property (
      wr7 ##1 !i_reg_wr |=>
      (o_np_word & 16'hb7ff) == ($past(i_reg_wdata, 2) & 16'hb7ff))
      else $error("next page word mismatch");
   chk_tx_rsv: assert property (!o_np_word[14])
      else $error("word reserved bit set");
   chk_toggle_load: assert property (
      i_base_sent |-> ##2 o_np_word[11] != $past(i_base_word[11], 2))
      else $error("toggle not loaded from base word");
   chk_toggle_flip: assert property (
      i_page_sent && !i_base_sent |-> ##2
      o_np_word[11] != $past(o_np_word[11]))
      else $error("toggle did not invert");
   cover property (rd6 ##1 o_reg_rdata[4]);
   cover property (i_page_sent);
   cover property (i_reg_wr && i_override_en);
endmodule : anxr_regs_monitor
bind anxr_regs anxr_regs_monitor u_mon (.*);
`default_nettype wire

// *** anxr_sta.sv ***
// Station management model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module anxr_sta (
   // Clock
   input wire logic i_clk,
   // Register strobes
   output logic [4:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [15:0] o_wdata,
   input wire logic [15:0] i_rdata
);
   initial begin
      {o_addr, o_wr, o_rd, o_wdata} = '0;
   end
   task automatic access(input logic w, input logic [4:0] a,
      input logic [15:0] d, output logic [15:0] q);
      @(posedge i_clk);
      o_addr <= a;
      o_wr <= w;
      o_rd <= !w;
      o_wdata <= d & ((a == 5'h06) ? 16'h001f : 16'hbfff);
      @(posedge i_clk);
      {o_wr, o_rd} <= 2'b00;
      @(posedge i_clk);
      q = i_rdata;
   endtask : access
endmodule : anxr_sta
`default_nettype wire

// *** anxr_regs_test.sv ***
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module anxr_regs_test;
   typedef struct packed {logic [15:0] d; logic [15:0] e;} anxr_row_t;
   logic clk = 1'b0, rst_n = 1'b0, ovr = 1'b0, pdf = 1'b0, pst = 1'b0;
   logic pnp = 1'b0, flp = 1'b0, bsent = 1'b0, psent = 1'b0;
   logic [15:0] bword = 16'h0000, q;
   wire logic [4:0] addr;
   wire logic wr, rd;
   wire logic [15:0] wdata, rdata, npw;
   int mismatches = 0;
   int num_checks = 0;
   anxr_row_t rows [4] = '{'{16'hffff, 16'hb7ff}, '{16'h0000, 16'h0000},
      '{16'h9555, 16'h9555}, '{16'h2001, 16'h2001}};
   anxr_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_override_en(ovr), .i_pd_fault(pdf), .i_page_stored(pst),
      .i_partner_np(pnp), .i_flp_valid(flp), .i_base_sent(bsent),
      .i_base_word(bword), .i_page_sent(psent), .o_np_word(npw));
   anxr_sta sta (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
      .o_wdata(wdata), .i_rdata(rdata));
   always #5 clk = ~clk;
   //==========================================================
   // Helpers
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      sta.access(1'b0, a, 16'h0000, q);
      check(q, e);
   endtask : rd_chk
   task automatic pulse(input logic b, input logic p, input logic [15:0] w);
      @(posedge clk);
      bword <= w;
      bsent <= b;
      psent <= p;
      @(posedge clk);
      {bsent, psent} <= 2'b00;
   endtask : pulse
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   //==========================================================
   // Tests
   initial begin
      #20000;
      mismatches++;
      stop_test();
   end
   initial begin
      do_reset();
      rd_chk(5'h06, 16'h0004);
      rd_chk(5'h07, 16'h2001);
      check(npw, 16'h2001);
      foreach (rows[i]) begin
         sta.access(1'b1, 5'h07, rows[i].d, q);
         rd_chk(5'h07, rows[i].e);
         check(npw, rows[i].e);
      end
      $display("test reset and rows done");
      @(posedge clk);
      {pdf, pst, pnp, flp} <= 4'hf;
      @(posedge clk);
      {pdf, pst, pnp, flp} <= 4'h0;
      rd_chk(5'h06, 16'h001f);
      rd_chk(5'h06, 16'h000d);
      fork
         sta.access(1'b0, 5'h06, 16'h0000, q);
         begin
            @(posedge clk);
            pdf <= 1'b1;
            @(posedge clk);
            pdf <= 1'b0;
         end
      join
      check(q, 16'h000d);
      rd_chk(5'h06, 16'h001d);
      for (int k = 0; k < 2; k++) begin
         ovr <= k[0];
         sta.access(1'b1, 5'h06, 16'h001f, q);
         rd_chk(5'h06, 16'h000d);
      end
      sta.access(1'b1, 5'h1f, 16'hffff, q);
      rd_chk(5'h1f, 16'h0000);
      $display("test events done");
      pulse(1'b1, 1'b0, 16'h0000);
      rd_chk(5'h07, 16'h2801);
      check(npw, 16'h2801);
      pulse(1'b0, 1'b1, 16'h0000);
      rd_chk(5'h07, 16'h2001);
      pulse(1'b0, 1'b1, 16'h0000);
      rd_chk(5'h07, 16'h2801);
      pulse(1'b1, 1'b1, 16'h0000);
      rd_chk(5'h07, 16'h2801);
      pulse(1'b1, 1'b0, 16'h0800);
      rd_chk(5'h07, 16'h2001);
      check(npw, 16'h2001);
      $display("test toggle done");
      sta.access(1'b1, 5'h07, 16'h9555, q);
      do_reset();
      rd_chk(5'h06, 16'h0004);
      rd_chk(5'h07, 16'h2001);
      check(npw, 16'h2001);
      $display("test second reset done");
      stop_test();
   end
endmodule : anxr_regs_test
`default_nettype wire
